// ---- logic/uab_defs.vh ----
/*
 * register map, field positions, reset values and prescale figures of
 * the auto-baud measurement block.
 * assumes: included by bare name from the design files of this block.
 */
`ifndef UAB_DEFS_VH
`define UAB_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------------
`define UAB_OFS_TX_STATUS_CONTROL 8'h00
`define UAB_OFS_BAUD_CONTROL      8'h04
`define UAB_OFS_DIVISOR_LOW       8'h08
`define UAB_OFS_DIVISOR_HIGH      8'h0c
`define UAB_OFS_RECEIVE_BUFFER    8'h10
`define UAB_OFS_IRQ_STATUS        8'h14
`define UAB_OFS_IRQ_MASK          8'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UAB_TSC_HIGH_SPEED   2
`define UAB_TSC_SYNC_MODE    4
`define UAB_BC_AUTOBAUD_EN   0
`define UAB_BC_WAKE_BREAK    1
`define UAB_BC_WIDE_DIVISOR  3
`define UAB_BC_RX_IDLE       6
`define UAB_IRQ_MEASURE_DONE 0
`define UAB_IRQ_BREAK_SEEN   1
`define UAB_IRQ_RECEIVE      2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define UAB_RST_TX_STATUS_CONTROL 8'h00
`define UAB_RST_BAUD_CONTROL      8'h00
`define UAB_RST_BC_BIT            1'b0
`define UAB_RST_DIVISOR           16'h0000
`define UAB_RST_IRQ_MASK          3'h0

// ----------------------------------------------------------------------
// oscillator divides of the normal bit clock, and the calibration slowdown
// ----------------------------------------------------------------------
`define UAB_DIV_SLOW     10'h040
`define UAB_DIV_MID      10'h010
`define UAB_DIV_FAST     10'h004
`define UAB_CAL_SLOWDOWN 10'h008
`define UAB_EDGES_DONE   3'h5

`endif

// ---- logic/uab_tick_gen.v ----
/*
 * prescaler: one-cycle tick every divide clocks of the oscillator.
 * assumes: divide is at least one and changes only between uses; restart
 * aligns the phase so a measurement starts from a clean count.
 */
`timescale 1ns/1ps
module uab_tick_gen #(
    parameter WIDTH = 10
) (
    input  wire             clock,
    input  wire             rst_n,
    input  wire             restart,
    input  wire [WIDTH-1:0] divide,
    output reg              tick
);
    reg [WIDTH-1:0] count_r;

    always @(posedge clock) begin
        if (!rst_n) begin
            count_r <= {WIDTH{1'b0}};
            tick    <= 1'b0;
        end else if (restart) begin
            count_r <= {WIDTH{1'b0}};
            tick    <= 1'b0;
        end else if (count_r >= divide - {{(WIDTH-1){1'b0}}, 1'b1}) begin
            count_r <= {WIDTH{1'b0}};
            tick    <= 1'b1;
        end else begin
            count_r <= count_r + {{(WIDTH-1){1'b0}}, 1'b1};
            tick    <= 1'b0;
        end
    end
endmodule // uab_tick_gen

// ---- logic/uab_detector.v ----
/*
 * auto-baud measurement of an asynchronous receiver with its baud
 * generator, apb register slave and one level interrupt.
 * assumes: rx_pin is asynchronous to clock; the receive datapath outside
 * obeys rx_hold_idle and delivers characters on rx_char_valid/rx_char.
 */
`timescale 1ns/1ps
`include "uab_defs.vh"

// What the block, its software and the far transmitter must do
// RQ1: measure only in asynchronous mode.
// RQ2: a start bit with autobaud enable set begins a measurement.
// RQ3: setting autobaud enable zeroes the counter, then waits for start.
// RQ4: the far transmitter sends 55h as the calibration character.
// RQ5: counting spans both low and high bit times to average asymmetry.
// RQ6: counting begins on the first rising edge after the start bit.
// RQ7: at the fifth rising edge the count stays in the divisor pair.
// RQ8: the fifth rising edge clears autobaud enable by hardware.
// RQ9: during calibration the counter runs at one eighth the normal rate.
// RQ10: both divisor bytes form one 16-bit counter whatever wide select.
// RQ11: rate selects give oscillator over 512, 128 or 32.
// RQ12: the receive state machine is held idle while measuring.
// RQ13: the fifth rising edge raises the receive-complete flag.
// RQ14: reading the receive buffer clears the flag; software discards it.
// RQ15: with wake-on-break also set, measure the character after break.
// RQ16: software keeps the expected rate within the measurable range.
// RQ17: high speed select is bit 2, wide divisor select is bit 3.
// RQ18: after measurement the generator times bits with the new divisor.
module uab_detector (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        rx_pin,
    input  wire        rx_char_valid,
    input  wire [7:0]  rx_char,
    output wire        rx_hold_idle,
    output reg         baud_tick,
    output wire        irq
);
    // ------------------------------------------------------------------
    // states of the measurement sequencer
    // ------------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_START = 3'd1;
    localparam [2:0] ST_FIRST = 3'd2;
    localparam [2:0] ST_COUNT = 3'd3;
    localparam [2:0] ST_BREAK = 3'd4;

    reg  [7:0]  tsc_r;
    reg         autobaud_enable_r;
    reg         wake_on_break_enable_r;
    reg         wide_divisor_select_r;
    reg  [15:0] divisor_r;
    reg  [15:0] divisor_nxt;
    reg  [7:0]  receive_buffer_r;
    reg         receive_complete_flag_r;
    reg  [2:0]  irq_status_r;
    reg  [2:0]  irq_mask_r;
    reg  [2:0]  state_r;
    reg  [2:0]  edges_r;
    reg  [15:0] gen_count_r;
    reg         rx_meta_r;
    reg         rx_sync_r;
    reg         rx_prev_r;
    reg  [9:0]  base_div;
    reg  [9:0]  tick_div;
    reg  [31:0] rd_word;
    reg         rd_hit;

    wire        async_mode;
    wire        rx_rise;
    wire        rx_fall;
    wire        measuring;
    wire        tick;
    wire        wr_en;
    wire        rd_en;
    wire        set_autobaud;
    wire        done_fifth;
    wire        break_end;
    wire        rd_buffer;
    wire        rd_status;

    // ------------------------------------------------------------------
    // rx pin synchroniser and edge detect
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
            rx_prev_r <= 1'b1;
        end else begin
            rx_meta_r <= rx_pin;
            rx_sync_r <= rx_meta_r;
            rx_prev_r <= rx_sync_r;
        end
    end

    assign rx_rise = rx_sync_r & ~rx_prev_r;
    assign rx_fall = ~rx_sync_r & rx_prev_r;

    // ------------------------------------------------------------------
    // apb access decode
    // ------------------------------------------------------------------
    // zero wait states: every access completes on its first access edge
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pslverr = psel & penable & ~rd_hit;
    assign rd_buffer = rd_en & (paddr == `UAB_OFS_RECEIVE_BUFFER);
    assign rd_status = rd_en & (paddr == `UAB_OFS_IRQ_STATUS);
    assign set_autobaud = wr_en & (paddr == `UAB_OFS_BAUD_CONTROL)
                        & pwdata[`UAB_BC_AUTOBAUD_EN] & ~autobaud_enable_r;

    assign async_mode = ~tsc_r[`UAB_TSC_SYNC_MODE];
    assign measuring  = (state_r == ST_FIRST) | (state_r == ST_COUNT);
    assign rx_hold_idle = autobaud_enable_r & async_mode;        // RQ12
    assign done_fifth = (state_r == ST_COUNT) & rx_rise
                      & (edges_r == `UAB_EDGES_DONE - 3'h1);
    assign break_end  = (state_r == ST_BREAK) & rx_rise;

    always @* begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        case (paddr)
            `UAB_OFS_TX_STATUS_CONTROL: rd_word[7:0] = tsc_r;
            `UAB_OFS_BAUD_CONTROL: begin
                rd_word[`UAB_BC_AUTOBAUD_EN]  = autobaud_enable_r;
                rd_word[`UAB_BC_WAKE_BREAK]   = wake_on_break_enable_r;
                rd_word[`UAB_BC_WIDE_DIVISOR] = wide_divisor_select_r;
                rd_word[`UAB_BC_RX_IDLE]      = ~measuring;
            end
            `UAB_OFS_DIVISOR_LOW:    rd_word[7:0] = divisor_r[7:0];
            `UAB_OFS_DIVISOR_HIGH:   rd_word[7:0] = divisor_r[15:8];
            `UAB_OFS_RECEIVE_BUFFER: rd_word[7:0] = receive_buffer_r;
            `UAB_OFS_IRQ_STATUS:     rd_word[2:0] = irq_status_r;
            `UAB_OFS_IRQ_MASK:       rd_word[2:0] = irq_mask_r;
            default:                 rd_hit = 1'b0;
        endcase
    end

    // read data captured in the setup cycle so prdata comes from a flop
    always @(posedge clock) begin
        if (!rst_n)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable & ~pwrite)
            prdata <= rd_word;
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            tsc_r                  <= `UAB_RST_TX_STATUS_CONTROL;
            autobaud_enable_r      <= `UAB_RST_BC_BIT;
            wake_on_break_enable_r <= `UAB_RST_BC_BIT;
            wide_divisor_select_r  <= `UAB_RST_BC_BIT;
            irq_mask_r             <= `UAB_RST_IRQ_MASK;
        end else begin
            if (wr_en & (paddr == `UAB_OFS_TX_STATUS_CONTROL))
                tsc_r <= pwdata[7:0];
            if (wr_en & (paddr == `UAB_OFS_IRQ_MASK))
                irq_mask_r <= pwdata[2:0];
            if (wr_en & (paddr == `UAB_OFS_BAUD_CONTROL)) begin
                wide_divisor_select_r <= pwdata[`UAB_BC_WIDE_DIVISOR];
                wake_on_break_enable_r <= pwdata[`UAB_BC_WAKE_BREAK];
            end else if (break_end) begin
                wake_on_break_enable_r <= 1'b0;                 // RQ15
            end
            // hardware clear wins over a simultaneous software write
            if (done_fifth)
                autobaud_enable_r <= 1'b0;                      // RQ8
            else if (wr_en & (paddr == `UAB_OFS_BAUD_CONTROL))
                autobaud_enable_r <= pwdata[`UAB_BC_AUTOBAUD_EN];
        end
    end

    // ------------------------------------------------------------------
    // counter clock selection
    // ------------------------------------------------------------------
    always @* begin
        case ({wide_divisor_select_r, tsc_r[`UAB_TSC_HIGH_SPEED]}) // RQ17
            2'b00:   base_div = `UAB_DIV_SLOW;
            2'b11:   base_div = `UAB_DIV_FAST;
            default: base_div = `UAB_DIV_MID;
        endcase
        // slow by eight while calibrating: 512, 128 or 32 clocks
        if (measuring)
            tick_div = base_div * `UAB_CAL_SLOWDOWN;           // RQ9 RQ11
        else
            tick_div = base_div;
    end

    uab_tick_gen #(
        .WIDTH   (10)
    ) u_tick (
        .clock   (clock),
        .rst_n   (rst_n),
        .restart (set_autobaud | (state_r == ST_FIRST & rx_rise)),
        .divide  (tick_div),
        .tick    (tick)
    );

    // ------------------------------------------------------------------
    // measurement sequencer
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            edges_r <= 3'h0;
        end else if (~autobaud_enable_r | ~async_mode) begin
            state_r <= ST_IDLE;                                 // RQ1
            edges_r <= 3'h0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    edges_r <= 3'h0;
                    if (wake_on_break_enable_r)
                        state_r <= ST_BREAK;                    // RQ15
                    else
                        state_r <= ST_START;                    // RQ3
                end
                ST_BREAK: begin
                    if (break_end)
                        state_r <= ST_START;
                end
                ST_START: begin
                    if (wake_on_break_enable_r)
                        state_r <= ST_BREAK;
                    else if (rx_fall)
                        state_r <= ST_FIRST;                    // RQ2
                end
                ST_FIRST: begin
                    if (rx_rise) begin
                        state_r <= ST_COUNT;                    // RQ6
                        edges_r <= 3'h1;
                    end
                end
                ST_COUNT: begin
                    // edges at bits 0,2,4,6 and stop: low and high times
                    if (done_fifth)
                        state_r <= ST_IDLE;                     // RQ5 RQ7
                    else if (rx_rise)
                        edges_r <= edges_r + 3'h1;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // divisor pair: 16-bit measure counter or software value
    // ------------------------------------------------------------------
    always @* begin
        divisor_nxt = divisor_r;
        if (wr_en & (paddr == `UAB_OFS_DIVISOR_LOW))
            divisor_nxt[7:0] = pwdata[7:0];
        if (wr_en & (paddr == `UAB_OFS_DIVISOR_HIGH))
            divisor_nxt[15:8] = pwdata[7:0];
        // zeroed even with wake set: the break leaves the counter alone
        if (set_autobaud & async_mode)
            divisor_nxt = 16'h0000;                             // RQ3
        else if ((state_r == ST_COUNT) & tick & ~done_fifth)
            divisor_nxt = divisor_r + 16'h0001;                 // RQ10
    end

    always @(posedge clock) begin
        if (!rst_n)
            divisor_r <= `UAB_RST_DIVISOR;
        else
            divisor_r <= divisor_nxt;
    end

    // ------------------------------------------------------------------
    // normal baud generator, idle while measuring
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            gen_count_r <= 16'h0000;
            baud_tick   <= 1'b0;
        end else if (rx_hold_idle) begin
            gen_count_r <= 16'h0000;
            baud_tick   <= 1'b0;
        end else if (tick) begin
            // the freshly measured divisor is used with no software step
            if (gen_count_r == 16'h0000) begin
                gen_count_r <= wide_divisor_select_r ? divisor_r
                             : {8'h00, divisor_r[7:0]};         // RQ18
                baud_tick   <= 1'b1;
            end else begin
                gen_count_r <= gen_count_r - 16'h0001;
                baud_tick   <= 1'b0;
            end
        end else begin
            baud_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // receive buffer, receive-complete flag and interrupt status
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (!rst_n) begin
            receive_buffer_r        <= 8'h00;
            receive_complete_flag_r <= 1'b0;
            irq_status_r            <= 3'h0;
        end else begin
            if (rx_char_valid & ~rx_hold_idle)
                receive_buffer_r <= rx_char;
            // set wins over the clear by a read in the same cycle
            if (done_fifth | (rx_char_valid & ~rx_hold_idle))
                receive_complete_flag_r <= 1'b1;                // RQ13
            else if (rd_buffer)
                receive_complete_flag_r <= 1'b0;                // RQ14
            // clear only what the read reported: an event landing after
            // the setup-cycle capture must not be lost
            irq_status_r <= (irq_status_r
                             & ~(rd_status ? prdata[2:0] : 3'h0))
                          | {receive_complete_flag_r & ~rd_buffer,
                             break_end, done_fifth};
        end
    end

    assign irq = |(irq_status_r & irq_mask_r);
endmodule // uab_detector

// ---- verification/uab_detector_sva.sv ----
/* port checker of the auto-baud block.
   assumes: bound to uab_detector; one clock, synchronous reset. */
`timescale 1ns/1ps
module uab_detector_chk (
    input logic        clock,
    input logic        rst_n,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [7:0]  paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        rx_pin,
    input logic        rx_char_valid,
    input logic [7:0]  rx_char,
    input logic        rx_hold_idle,
    input logic        baud_tick,
    input logic        irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic acc;
    assign acc = psel && penable;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    pready_high_a: assert property (pready)
        else $error("pready low");
    err_access_a: assert property (pslverr |-> acc)
        else $error("pslverr outside access");
    err_mapped_a: assert property
        (acc && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("pslverr on mapped address");
    err_data_a: assert property (acc && pslverr && !pwrite |-> prdata == 0)
        else $error("unmapped read data not zero");
    rdata_setup_a: assert property (!$stable(prdata) |-> $past(psel && !penable))
        else $error("prdata moved outside setup");
    hold_start_a: assert property ($rose(rx_hold_idle) |-> $past(acc && pwrite))
        else $error("receiver held without write");
    hold_stop_a: assert property
        ($fell(rx_hold_idle) |-> $past(acc && pwrite) || $past(rx_pin, 2))
        else $error("measurement ended without rising line");
    tick_pulse_a: assert property (baud_tick |=> !baud_tick)
        else $error("bit tick longer than one cycle");
    irq_fall_a: assert property ($fell(irq) |-> $past(acc))
        else $error("interrupt dropped without bus access");
    cover property ($fell(rx_hold_idle));
    cover property (acc && pslverr);
    cover property ($rose(irq));
endmodule // uab_detector_chk

bind uab_detector uab_detector_chk chk_u (.clock(clock), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_pin(rx_pin), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .rx_hold_idle(rx_hold_idle), .baud_tick(baud_tick), .irq(irq));

// ---- verification/uab_tx_model.sv ----
/* far transmitter: sends one calibration character, optionally after a
   break, at a bit period given in clocks.
   assumes: bench clock; the line idles high between frames. */
`timescale 1ns/1ps
module uab_tx_model (
    input  logic        clock,
    input  logic        send,
    input  logic        with_break,
    input  logic [15:0] bit_clocks,
    output logic        rx_pin,
    output logic        busy
);
    // lsb first: start, data, stop
    localparam logic [9:0] FRAME = {1'b1, 8'h55, 1'b0};
    int i;
    initial begin
        rx_pin = 1'b1;
        busy = 1'b0;
    end
    always @(posedge clock) begin
        if (send && !busy) begin
            busy <= 1'b1;
            if (with_break) begin
                rx_pin <= 1'b0;
                repeat (12 * bit_clocks) @(posedge clock);
                rx_pin <= 1'b1;
                repeat (bit_clocks) @(posedge clock);
            end
            for (i = 0; i < 10; i++) begin
                rx_pin <= FRAME[i];
                repeat (bit_clocks) @(posedge clock);
            end
            busy <= 1'b0;
        end
    end
endmodule // uab_tx_model

// ---- verification/tb_top.sv ----
/* bench of the auto-baud block: apb master, far transmitter model.
   assumes: design, checker and model compiled first. */
`timescale 1ns/1ps
`include "uab_defs.vh"
module tb_top;
    logic        clock, rst_n, psel, penable, pwrite, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, lo;
    logic        pready, pslverr, rx_pin, rx_hold_idle, baud_tick, irq;
    logic        send, brk, busy;
    logic [15:0] bitc;
    int          failures = 0;
    int          total_checks = 0;

    uab_detector dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .rx_char_valid(1'b0), .rx_char(8'h00), .rx_hold_idle(rx_hold_idle),
        .baud_tick(baud_tick), .irq(irq));
    uab_tx_model far_u (.clock(clock), .send(send), .with_break(brk),
        .bit_clocks(bitc), .rx_pin(rx_pin), .busy(busy));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] e,
                         input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            $display("MISMATCH pready expected 1 seen %b", pready);
            failures++;
            results;
        end
    endtask
    task automatic divisor(input logic [15:0] e);
        apb(`UAB_OFS_DIVISOR_LOW, 1'b0, 32'h0);
        lo = rd;
        apb(`UAB_OFS_DIVISOR_HIGH, 1'b0, 32'h0);
        total_checks++;
        // one count of slack for synchroniser and prescaler phase
        if ({rd[7:0], lo[7:0]} + 16'h1 - e <= 16'h2) begin
        end else begin
            $display("MISMATCH divisor expected %h seen %h", e,
                     {rd[7:0], lo[7:0]});
            failures++;
        end
    endtask
    task automatic send_char(input logic [15:0] t, input logic b);
        int n;
        n = 0;
        @(posedge clock);
        bitc <= t;
        brk <= b;
        send <= 1'b1;
        @(posedge clock);
        send <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (busy !== 1'b0 && n < 25000);
        if (n >= 25000) begin
            $display("MISMATCH transmitter expected idle seen %b", busy);
            failures++;
            results;
        end
        repeat (8) @(posedge clock);
        @(negedge clock);
    endtask
    task automatic tick_gap(input logic hs, input logic wd);
        int n, p;
        n = 0;
        p = (hs & wd) ? `UAB_DIV_FAST : (hs | wd) ? `UAB_DIV_MID
          : `UAB_DIV_SLOW;
        p = p * ((wd ? {rd[7:0], lo[7:0]} : {8'h00, lo[7:0]}) + 1);
        while (baud_tick !== 1'b1 && n < 9000) begin
            @(posedge clock);
            n++;
        end
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (baud_tick !== 1'b1 && n < 9000);
        check("tick period", p, n);
        if (n >= 9000)
            results;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        logic [7:0] ofs [5];
        ofs = '{`UAB_OFS_TX_STATUS_CONTROL, `UAB_OFS_BAUD_CONTROL,
                `UAB_OFS_DIVISOR_LOW, `UAB_OFS_DIVISOR_HIGH,
                `UAB_OFS_IRQ_MASK};
        for (int k = 0; k < 5; k++) begin
            apb(ofs[k], 1'b0, 32'h0);
            check("reset value", 32'h0, rd & 32'hffffffbf);
        end
        apb(8'h1c, 1'b0, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        $display("test reset done");
    endtask
    task automatic t_measure(input logic hs, input logic wd,
                             input logic [15:0] t, input logic [15:0] e);
        apb(`UAB_OFS_IRQ_MASK, 1'b1, 32'h1);
        apb(`UAB_OFS_TX_STATUS_CONTROL, 1'b1, {29'h0, hs, 2'h0});
        apb(`UAB_OFS_BAUD_CONTROL, 1'b1, {28'h0, wd, 3'h1});
        @(negedge clock);
        check("receiver held", 32'h1, {31'h0, rx_hold_idle});
        apb(`UAB_OFS_DIVISOR_LOW, 1'b0, 32'h0);
        check("divisor cleared", 32'h0, rd);
        send_char(t, 1'b0);
        check("receiver released", 32'h0, {31'h0, rx_hold_idle});
        check("interrupt raised", 32'h1, {31'h0, irq});
        apb(`UAB_OFS_BAUD_CONTROL, 1'b0, 32'h0);
        check("enable cleared", 32'h0, rd & 32'h1);
        divisor(e);
        tick_gap(hs, wd);
        apb(`UAB_OFS_IRQ_MASK, 1'b1, 32'h0);
        @(negedge clock);
        check("interrupt masked", 32'h0, {31'h0, irq});
        apb(`UAB_OFS_IRQ_MASK, 1'b1, 32'h1);
        apb(`UAB_OFS_IRQ_STATUS, 1'b0, 32'h0);
        check("status", 32'h5, rd & 32'h5);
        @(negedge clock);
        check("interrupt cleared", 32'h0, {31'h0, irq});
        apb(`UAB_OFS_IRQ_STATUS, 1'b0, 32'h0);
        check("flag pending", 32'h4, rd & 32'h4);
        apb(`UAB_OFS_RECEIVE_BUFFER, 1'b0, 32'h0);
        apb(`UAB_OFS_IRQ_STATUS, 1'b0, 32'h0);
        apb(`UAB_OFS_IRQ_STATUS, 1'b0, 32'h0);
        check("receive flag", 32'h0, rd & 32'h4);
        $display("test measure done");
    endtask
    task automatic t_sync;
        apb(`UAB_OFS_TX_STATUS_CONTROL, 1'b1, 32'h10);
        apb(`UAB_OFS_BAUD_CONTROL, 1'b1, 32'h1);
        send_char(16'd96, 1'b0);
        check("no hold in sync", 32'h0, {31'h0, rx_hold_idle});
        apb(`UAB_OFS_BAUD_CONTROL, 1'b0, 32'h0);
        check("enable kept", 32'h1, rd & 32'h1);
        apb(`UAB_OFS_IRQ_STATUS, 1'b0, 32'h0);
        check("no measurement", 32'h0, rd & 32'h1);
        apb(`UAB_OFS_BAUD_CONTROL, 1'b1, 32'h0);
        apb(`UAB_OFS_TX_STATUS_CONTROL, 1'b1, 32'h0);
        $display("test sync done");
    endtask
    task automatic t_break;
        apb(`UAB_OFS_TX_STATUS_CONTROL, 1'b1, 32'h4);
        apb(`UAB_OFS_BAUD_CONTROL, 1'b1, 32'hb);
        send_char(16'd96, 1'b1);
        apb(`UAB_OFS_BAUD_CONTROL, 1'b0, 32'h0);
        check("enable and wake", 32'h0, rd & 32'h3);
        divisor(16'd24);
        $display("test break done");
    endtask

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        send = 1'b0;
        brk = 1'b0;
        bitc = 16'h0001;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_measure(1'b0, 1'b0, 16'd1024, 16'd16);
        t_measure(1'b1, 1'b0, 16'd256, 16'd16);
        t_measure(1'b0, 1'b1, 16'd256, 16'd16);
        t_measure(1'b1, 1'b1, 16'd2048, 16'd512);
        t_sync;
        t_break;
        results;
    end
endmodule // tb_top
